// ---- rtl/adcs_coder.sv ----
// single ended and differential result coding
`timescale 1ns/100ps
module adcs_coder
  import adcs_pkg::*;
(
  adcs_code_if.cod c
);
  logic signed [11:0] half;
  // raw is vin*1024/vref, floored; diff scale is half
  always_comb begin
    half = c.raw >>> 1;
    if (!c.is_diff) begin
      if (c.raw < 0)
        c.code = SE_MIN;
      else if (c.raw > RAW_SE_MAX)
        c.code = SE_MAX;
      else
        c.code = c.raw[9:0];
    end else begin
      if (half > RAW_D_MAX)
        c.code = DIFF_MAX;
      else if (half < RAW_D_MIN)
        c.code = DIFF_MIN;
      else
        c.code = half[9:0];
    end
  end
endmodule

// ---- rtl/adcs_sync.sv ----
// two flop synchroniser, parameter width
`timescale 1ns/100ps
module adcs_sync
  import adcs_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ---- rtl/adcs_top.sv ----
// input select register, mux control and result formatting
//
// Contract
// - single ended code 0 to 3ff, unsigned
// - single ended code is vin*1024/vref
// - differential two's complement, 200 to 1ff
// - left adjust puts result in top bits
// - adjust change re-presents result at once
// - select layout ref 7:6, adj 5, chan
// - ref codes ext, supply, reserved, internal
// - ref and channel writes during a conversion apply after it completes
// - codes 0-7 single ended, 8-15 none
// - differential pairs against input 1 or 2
// - code 1e bandgap, 1f ground
// - done flag set with result update
`timescale 1ns/100ps
module adcs_top
  import adcs_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic [7:0]         addr,
  input  wire logic [7:0]         wdata,
  input  wire logic               wr_stb,
  input  wire logic               rd_stb,
  output logic      [7:0]         rdata,
  input  wire logic               conv_busy,
  input  wire logic               conv_done_tgl,
  input  wire logic signed [11:0] conv_sample,
  output logic      [3:0]         mux_pos,
  output logic      [3:0]         mux_neg,
  output logic                    diff_en,
  output logic      [1:0]         ref_sel,
  output logic                    int_ref_en,
  output logic                    irq
);
  logic [7:0]         select_reg;
  logic [7:0]         applied_reg;
  logic [9:0]         result_reg;
  logic [1:0]         status_reg;
  logic [1:0]         mask_reg;
  logic               busy_s;
  logic               done_s;
  logic               done_d_reg;
  logic               busy_d_reg;
  logic signed [11:0] sample_s;
  logic               done_ev;
  logic               start_ev;
  logic [15:0]        res_pair;
  logic [3:0]         pos_next;
  logic [3:0]         neg_next;
  logic               diff_next;
  logic [7:0]         rd_next;
  logic [1:0]         st_set;
  logic [1:0]         st_clr;
  logic [1:0]         settle_reg;
  adcs_code_if        cif ();
  // both sync stages plus the edge flop must hold pin values
  localparam logic [1:0] SETTLE_DONE = 2'(SYNC_STAGES + 1);

  // pins from the analog side cross in first
  adcs_sync #(.W(1)) u_sync_busy (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       (conv_busy),
    .q       (busy_s)
  );
  adcs_sync #(.W(1)) u_sync_done (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       (conv_done_tgl),
    .q       (done_s)
  );
  // sample is held stable before the toggle flips
  adcs_sync #(.W(12)) u_sync_smp (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       (conv_sample),
    .q       (sample_s)
  );
  adcs_coder u_coder (
    .c (cif.cod)
  );

  // edge detect after the synchronisers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      done_d_reg <= 1'b0;
      busy_d_reg <= 1'b0;
    end else begin
      done_d_reg <= done_s;
      busy_d_reg <= busy_s;
    end
  end

  // syncs restart at zero while the pins may sit high after a mid-run
  // reset; edges are ignored until the stages carry real pin values
  always_ff @(posedge clk_sys) begin
    if (srst)
      settle_reg <= 2'h0;
    else if (settle_reg != SETTLE_DONE)
      settle_reg <= settle_reg + 2'h1;
  end
  assign done_ev  = (done_s ^ done_d_reg) & (settle_reg == SETTLE_DONE);
  assign start_ev = busy_s & ~busy_d_reg & (settle_reg == SETTLE_DONE);

  // select register, all bits kept as written
  always_ff @(posedge clk_sys) begin
    if (srst)
      select_reg <= SELECT_RST;
    else if (wr_stb && addr == OFS_SELECT)
      select_reg <= wdata;
  end

  // shadow copy locked while a conversion runs
  always_ff @(posedge clk_sys) begin
    if (srst)
      applied_reg <= SELECT_RST;
    else if (!busy_s || done_ev)
      applied_reg <= select_reg;
  end

  // channel decode from the applied code
  always_comb begin
    pos_next  = SRC_NONE;
    neg_next  = SRC_NONE;
    diff_next = 1'b0;
    case (applied_reg[CHAN_HI:CHAN_HI-1])
      2'b00: begin
        pos_next = {1'b0, applied_reg[2:0]};
      end
      2'b01: begin
        pos_next = SRC_NONE;
      end
      2'b10: begin
        pos_next  = {1'b0, applied_reg[2:0]};
        neg_next  = SRC_NEG1;
        diff_next = 1'b1;
      end
      2'b11: begin
        if (applied_reg[2:0] <= LAST_NEG2_POS) begin
          pos_next  = {1'b0, applied_reg[2:0]};
          neg_next  = SRC_NEG2;
          diff_next = 1'b1;
        end else if (applied_reg[0] == 1'b0) begin
          pos_next = SRC_BG;
        end else begin
          pos_next = SRC_GND;
        end
      end
      default: begin
        pos_next = SRC_NONE;
      end
    endcase
  end

  // mux and reference drive, all registered
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mux_pos    <= 4'h0;
      mux_neg    <= SRC_NONE;
      diff_en    <= 1'b0;
      ref_sel    <= REF_EXT;
      int_ref_en <= 1'b0;
    end else begin
      mux_pos    <= pos_next;
      mux_neg    <= neg_next;
      diff_en    <= diff_next;
      ref_sel    <= applied_reg[REF_HI:REF_LO];
      int_ref_en <= applied_reg[REF_HI:REF_LO] == REF_BG;
    end
  end

  // coding uses the mode the sample was taken in
  assign cif.raw     = sample_s;
  assign cif.is_diff = diff_en;

  // result store on completion
  always_ff @(posedge clk_sys) begin
    if (srst)
      result_reg <= 10'h000;
    else if (done_ev)
      result_reg <= cif.code;
  end

  // adjust is read live, not latched with the result
  assign res_pair = select_reg[LADJ] ? {result_reg, 6'h00}
                                     : {6'h00, result_reg};

  // sticky events, set beats write-one clear
  assign st_set = {start_ev, done_ev};
  assign st_clr = (wr_stb && addr == OFS_STATUS) ? wdata[1:0] : 2'h0;
  always_ff @(posedge clk_sys) begin
    if (srst)
      status_reg <= ST_RST;
    else
      status_reg <= (status_reg & ~st_clr) | st_set;
  end

  always_ff @(posedge clk_sys) begin
    if (srst)
      mask_reg <= ST_RST;
    else if (wr_stb && addr == OFS_MASK)
      mask_reg <= wdata[1:0] & ST_USED;
  end

  // one cycle behind the status bits
  always_ff @(posedge clk_sys) begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(status_reg & mask_reg);
  end

  // read mux; unmapped reads give zero
  always_comb begin
    case (addr)
      OFS_SELECT: rd_next = select_reg;
      OFS_RES_LO: rd_next = res_pair[7:0];
      OFS_RES_HI: rd_next = res_pair[15:8];
      OFS_STATUS: rd_next = {6'h00, status_reg};
      OFS_MASK:   rd_next = {6'h00, mask_reg};
      default:    rd_next = 8'h00;
    endcase
  end

  // data only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst)
      rdata <= 8'h00;
    else if (rd_stb)
      rdata <= rd_next;
    else
      rdata <= 8'h00;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_SEL_RB: assert property (
    wr_stb && addr == OFS_SELECT ##1 rd_stb && addr == OFS_SELECT |=>
      rdata == $past(wdata, 2))
    else $error("select readback wrong");
  AST_LOCK: assert property (
    busy_s && !done_ev && $past(busy_s) |=> $stable(applied_reg))
    else $error("select changed during conversion");
  AST_APPLY: assert property (
    done_ev |=> applied_reg == $past(select_reg))
    else $error("select not applied at completion");
  AST_DONE_FLAG: assert property (
    done_ev |=> status_reg[ST_DONE] && result_reg == $past(cif.code))
    else $error("flag or result not updated");
  AST_LADJ: assert property (
    rd_stb && addr == OFS_RES_HI && select_reg[LADJ] |=>
      rdata == $past(result_reg[9:2]))
    else $error("left adjust high byte wrong");
  AST_RADJ: assert property (
    rd_stb && addr == OFS_RES_LO && !select_reg[LADJ] |=>
      rdata == $past(result_reg[7:0]))
    else $error("right adjust low byte wrong");
  AST_SE_RANGE: assert property (
    !cif.is_diff && cif.raw < 0 |-> cif.code == SE_MIN)
    else $error("negative single ended not zero");
  AST_DIFF_SAT: assert property (
    cif.is_diff && cif.raw > 12'sh3ff |-> cif.code == DIFF_MAX)
    else $error("differential not saturated");
  AST_BG: assert property (
    applied_reg[CHAN_HI:0] == 5'h1e ##1 applied_reg[CHAN_HI:0] == 5'h1e |->
      mux_pos == SRC_BG && !diff_en)
    else $error("bandgap not routed");
  AST_REF: assert property (
    ##1 int_ref_en == ($past(applied_reg[REF_HI:REF_LO]) == REF_BG))
    else $error("internal reference enable wrong");
  AST_IRQ: assert property (
    status_reg[ST_DONE] && mask_reg[ST_DONE] |=> irq)
    else $error("irq missing");
  AST_RDATA_IDLE: assert property (
    !rd_stb |=> rdata == 8'h00)
    else $error("read data outside the read cycle");
  AST_CLR: assert property (
    wr_stb && addr == OFS_STATUS && wdata[ST_DONE] && !done_ev |=> !status_reg[ST_DONE])
    else $error("done flag not cleared");
  AST_SE_MUX: assert property (
    applied_reg[CHAN_HI:CHAN_HI-1] == 2'b00 |=>
      !diff_en && mux_neg == SRC_NONE && mux_pos == {1'b0, $past(applied_reg[2:0])})
    else $error("single ended route wrong");
  AST_NONE: assert property (
    applied_reg[CHAN_HI:CHAN_HI-1] == 2'b01 |=> !diff_en && mux_pos == SRC_NONE && mux_neg == SRC_NONE)
    else $error("invalid channel routed");
  AST_DIFF_MUX: assert property (
    applied_reg[CHAN_HI:CHAN_HI-1] == 2'b10 |=>
      diff_en && mux_neg == SRC_NEG1 && mux_pos == {1'b0, $past(applied_reg[2:0])})
    else $error("pair against input 1 wrong");
  AST_LADJ_LO: assert property (
    rd_stb && addr == OFS_RES_LO && select_reg[LADJ] |=>
      rdata == {$past(result_reg[1:0]), 6'h00})
    else $error("left adjust low byte wrong");
  AST_RADJ_HI: assert property (
    rd_stb && addr == OFS_RES_HI && !select_reg[LADJ] |=>
      rdata == {6'h00, $past(result_reg[9:8])})
    else $error("right adjust high byte wrong");
  AST_RES_HOLD: assert property (
    !done_ev |=> $stable(result_reg))
    else $error("result changed without completion");

  COV_DONE: cover property (done_ev ##[1:20] rd_stb && addr == OFS_RES_LO);
  COV_LOCK: cover property (busy_s && wr_stb && addr == OFS_SELECT);
  COV_DIFF: cover property (done_ev && diff_en);
  COV_CLR_SET: cover property (done_ev && st_clr[ST_DONE]);
endmodule

// ---- shared/adcs_code_if.sv ----
// raw sample to coded result, between top and coder
`timescale 1ns/100ps
interface adcs_code_if;
  logic signed [11:0] raw;
  logic               is_diff;
  logic        [9:0]  code;
  modport ctl (output raw, output is_diff, input code);
  modport cod (input raw, input is_diff, output code);
endinterface

// ---- shared/adcs_pkg.sv ----
// constants for the input select and result format block
package adcs_pkg;
  // register offsets
  localparam logic [7:0] OFS_RES_LO = 8'h78;
  localparam logic [7:0] OFS_RES_HI = 8'h79;
  localparam logic [7:0] OFS_SELECT = 8'h7c;
  localparam logic [7:0] OFS_STATUS = 8'h70;
  localparam logic [7:0] OFS_MASK   = 8'h71;
  // select register fields and reset
  localparam int REF_HI  = 7;
  localparam int REF_LO  = 6;
  localparam int LADJ    = 5;
  localparam int CHAN_HI = 4;
  localparam logic [7:0] SELECT_RST = 8'h00;
  // status bits
  localparam int ST_DONE  = 0;
  localparam int ST_START = 1;
  localparam logic [1:0] ST_RST = 2'h0;
  localparam logic [1:0] ST_USED = 2'h3;
  // reference codes
  localparam logic [1:0] REF_EXT  = 2'h0;
  localparam logic [1:0] REF_SUPP = 2'h1;
  localparam logic [1:0] REF_RSVD = 2'h2;
  localparam logic [1:0] REF_BG   = 2'h3;
  // mux source codes
  localparam logic [3:0] SRC_BG   = 4'h8;
  localparam logic [3:0] SRC_GND  = 4'h9;
  localparam logic [3:0] SRC_NONE = 4'hf;
  localparam logic [3:0] SRC_NEG1 = 4'h1;
  localparam logic [3:0] SRC_NEG2 = 4'h2;
  localparam logic [2:0] LAST_NEG2_POS = 3'h5;
  // code limits
  localparam logic [9:0] SE_MAX   = 10'h3ff;
  localparam logic [9:0] SE_MIN   = 10'h000;
  localparam logic [9:0] DIFF_MAX = 10'h1ff;
  localparam logic [9:0] DIFF_MIN = 10'h200;
  localparam logic signed [11:0] RAW_SE_MAX = 12'sh3ff;
  localparam logic signed [11:0] RAW_D_MAX  = 12'sh1ff;
  localparam logic signed [11:0] RAW_D_MIN  = -12'sh200;
  localparam int SYNC_STAGES = 2;
endpackage

// ---- sim/adcs_conv_model.sv ----
// converter stand-in: busy level, done toggle, held sample
`timescale 1ns/100ps
module adcs_conv_model (
  input  wire logic          clk_sys,
  output logic               conv_busy,
  output logic               conv_done_tgl,
  output logic signed [11:0] conv_sample
);
  initial begin
    conv_busy = 1'b0;
    conv_done_tgl = 1'b0;
    conv_sample = 12'sh000;
  end
  // one conversion; len picks a prompt or slow answer
  task automatic convert(input logic signed [11:0] s, input int len);
    @(posedge clk_sys);
    conv_busy <= 1'b1;
    conv_sample <= s;
    repeat (len) @(posedge clk_sys); // sample settles well before the flip
    conv_done_tgl <= ~conv_done_tgl;
    repeat (2) @(posedge clk_sys);
    conv_busy <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

// ---- sim/testbench.sv ----
// self checking bench for the select and format block
`timescale 1ns/100ps
module testbench;
  import adcs_pkg::*;
  logic clk_sys, srst, wr_stb, rd_stb, rd_d, msk;
  logic conv_busy, conv_done_tgl, diff_en, int_ref_en, irq;
  logic [7:0] addr, wdata, rdata, sel;
  logic [3:0] mux_pos, mux_neg;
  logic [1:0] ref_sel;
  logic [8:0] m;
  logic signed [11:0] conv_sample;
  logic [7:0] exp_q[$];
  int n_errors, n_compared, cyc;

  adcs_top uut (.clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .conv_busy(conv_busy), .conv_done_tgl(conv_done_tgl), .conv_sample(conv_sample),
    .mux_pos(mux_pos), .mux_neg(mux_neg), .diff_en(diff_en), .ref_sel(ref_sel), .int_ref_en(int_ref_en),
    .irq(irq));
  adcs_conv_model far (.clk_sys(clk_sys), .conv_busy(conv_busy), .conv_done_tgl(conv_done_tgl),
    .conv_sample(conv_sample));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    if (exp_q.size() != 0) n_errors++;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask

  // expected read data is queued; the monitor pops it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    rd_stb <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_d) chk("rdata", exp_q.pop_front(), rdata);
    rd_d <= rd_stb;
    cyc <= cyc + 1;
    if (cyc > 4000) begin // whole run is under a thousand cycles
      n_errors++;
      summarize();
    end
  end

  // {diff, pos, neg} per channel code
  function automatic logic [8:0] mux_exp(input logic [4:0] c);
    if (c < 5'd8) return {2'b00, c[2:0], 4'hf};
    if (c < 5'd16) return 9'h0ff;
    if (c < 5'd24) return {2'b10, c[2:0], 4'h1};
    if (c < 5'd30) return {2'b10, c[2:0], 4'h2};
    return (c == 5'd30) ? 9'h08f : 9'h09f;
  endfunction

  function automatic logic [9:0] enc(input logic signed [11:0] r, input logic d);
    logic signed [11:0] v;
    v = d ? (r >>> 1) : r;
    if (d) return (v > 12'sh1ff) ? 10'h1ff : (v < -12'sh200) ? 10'h200 : v[9:0];
    return (v < 0) ? 10'h000 : (v > 12'sh3ff) ? 10'h3ff : v[9:0];
  endfunction

  // convert, then read both adjusts; adjust flips re-present the result
  task automatic conv_chk(input logic signed [11:0] r, input logic d, input int len);
    logic [9:0] c;
    c = enc(r, d);
    far.convert(r, len);
    rd(OFS_STATUS, 8'h03);
    wr(OFS_SELECT, sel & 8'hdf);
    rd(OFS_RES_LO, c[7:0]);
    rd(OFS_RES_HI, {6'h00, c[9:8]});
    wr(OFS_SELECT, sel | 8'h20);
    rd(OFS_RES_HI, c[9:2]);
    rd(OFS_RES_LO, {c[1:0], 6'h00});
    chk("irq", {7'h00, msk}, {7'h00, irq});
    wr(OFS_STATUS, 8'h03);
    rd(OFS_STATUS, 8'h00);
    chk("irq clear", 8'h00, {7'h00, irq});
  endtask

  initial begin
    srst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    rd_d = 1'b0;
    msk = 1'b1;
    n_errors = 0;
    n_compared = 0;
    cyc = 0;
    void'($urandom(32'h3e5a5778));
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    chk("reset outs", 8'hf0, {mux_neg, ref_sel, int_ref_en, irq});
    chk("reset mux", 8'h00, {mux_pos, 3'h0, diff_en});
    chk("reset rdata", 8'h00, rdata);
    rd(OFS_SELECT, SELECT_RST);
    rd(8'h55, 8'h00);
    rd(OFS_MASK, 8'h00);
    // random values, reserved codes included, read back whole
    repeat (8) begin
      sel = 8'($urandom);
      wr(OFS_SELECT, sel);
      rd(OFS_SELECT, sel);
    end
    // every channel code, reference codes cycled alongside
    for (int i = 0; i < 32; i++) begin
      sel = {i[1:0], 1'b0, i[4:0]};
      wr(OFS_SELECT, sel);
      repeat (4) @(posedge clk_sys);
      m = mux_exp(sel[4:0]);
      chk("ref", {5'h00, sel[7:6], sel[7:6] == 2'h3}, {5'h00, ref_sel, int_ref_en});
      chk("mux", m[7:0], {mux_pos, mux_neg});
      chk("diff_en", {7'h00, m[8]}, {7'h00, diff_en});
    end
    wr(OFS_MASK, 8'h01);
    sel = 8'h43;
    wr(OFS_SELECT, sel);
    repeat (4) @(posedge clk_sys);
    // select write while busy is held back until done
    fork
      far.convert(12'sh100, 20);
      begin
        repeat (6) @(posedge clk_sys);
        wr(OFS_SELECT, 8'h45);
        repeat (4) @(posedge clk_sys);
        chk("mux_pos held", 8'h03, {4'h0, mux_pos});
        rd(OFS_SELECT, 8'h45);
      end
    join
    chk("mux_pos", 8'h05, {4'h0, mux_pos});
    wr(OFS_STATUS, 8'h03);
    sel = 8'h40;
    wr(OFS_SELECT, sel);
    conv_chk(12'sh000, 1'b0, 4);
    conv_chk(12'sh3ff, 1'b0, 12);
    conv_chk(12'sh7ff, 1'b0, 4);
    conv_chk(-12'sh005, 1'b0, 4);
    repeat (4) conv_chk(12'($urandom_range(1023)), 1'b0, 5);
    msk = 1'b0;
    wr(OFS_MASK, 8'h00);
    sel = 8'hdb;
    wr(OFS_SELECT, sel);
    conv_chk(-12'sh0ba, 1'b1, 4);
    conv_chk(12'sh7ff, 1'b1, 9);
    conv_chk(-12'sh400, 1'b1, 4);
    conv_chk(-12'sh002, 1'b1, 4);
    // let the monitor take the last queued read
    repeat (2) @(posedge clk_sys);
    summarize();
  end
endmodule
